// ---- cfs_defs.svh ----
`ifndef CFS_DEFS_SVH
`define CFS_DEFS_SVH
// ---------------------------------------------
// register map
// ---------------------------------------------
`define CFS_REG_CTRL        4'h0
`define CFS_REG_STAT        4'h4
`define CFS_CTRL_AUTO       0
`define CFS_CTRL_USRCLK     1
`define CFS_CTRL_RST_AUTO   1'h1
`define CFS_CTRL_RST_USRCLK 1'h0
// ---------------------------------------------
// timing
// ---------------------------------------------
`define CFS_MCLK_NS         25
`define CFS_OSC_NS          100
`define CFS_RESTART_US      230
`define CFS_INIT_BASE       3185
`define CFS_INIT_SEC        3192
// pins hold their accepted level from the fourth edge on
`define CFS_SETTLE          4'h5
`define CFS_OD_LOW          1'h0
// ---------------------------------------------
// scheme_select codes
// ---------------------------------------------
`define CFS_SEL_ASER_STD33  4'h2
`define CFS_SEL_ASER_STD30  4'h3
`define CFS_SEL_ASER_FAST33 4'hD
`define CFS_SEL_ASER_FAST30 4'h4
`define CFS_SEL_APAR_STD33  4'h7
`define CFS_SEL_APAR_STD30  4'hB
`define CFS_SEL_APAR_STD18  4'h8
`define CFS_SEL_APAR_FAST33 4'h5
`define CFS_SEL_APAR_FAST18 4'h6
`define CFS_SEL_PSER_STD    4'h0
`define CFS_SEL_PSER_FAST   4'hC
`define CFS_SEL_FPAR_33     4'hE
`define CFS_SEL_FPAR_18_B   4'hF
`define CFS_SEL_FPAR_18_S   4'h1
`endif

// ---- cfs_pkg.sv ----
package cfs_pkg;
   // ---------------------------------------------
   // sequencer states
   // ---------------------------------------------
   typedef enum logic [3:0] {
      ST_POR, ST_RESET, ST_LOAD, ST_ERROR,
      ST_DONE_WAIT, ST_INIT, ST_USER
   } cfs_state_e;
   // ---------------------------------------------
   // decoded configuration scheme
   // ---------------------------------------------
   typedef enum logic [2:0] {
      SCH_NONE, SCH_ACTIVE_SERIAL, SCH_ACTIVE_PARALLEL,
      SCH_PASSIVE_SERIAL, SCH_FAST_PASSIVE_PARALLEL,
      SCH_FAST_PASSIVE_PARALLEL_ENC
   } cfs_scheme_e;
   typedef struct packed {
      cfs_scheme_e scheme;   // scheme family
      logic        fast_por; // fast power-on reset
      logic        valid;    // code legal here
   } cfs_scheme_s;
endpackage

// ---- cfs_ctrl.sv ----
// How it works
// [RL1] frame error: status low, load_complete low
// [RL2] auto restart: release status after timeout
// [RL3] host pulses reconfig low for restart
// [RL4] default init clock: internal 10 MHz
// [RL5] internal clock needs no user clock
// [RL6] user clock option: only init clock
// [RL7] loading ignores user startup clock
// [RL8] count 3185 or 3192 init cycles
// [RL9] host keeps user clock during restart
// [RL10] startup_complete low after option frame
// [RL11] release startup_complete on user mode
// [RL12] user mode drops weak pull-ups
// [RL13] decode active serial codes
// [RL14] base only: decode active parallel codes
// [RL15] decode passive serial codes
// [RL16] decode fast passive parallel codes
// [RL17] secure only: encrypted parallel codes
// [RL18] test port load overrides scheme_select
// [RL19] no top select bit: limited decode
// [RL20] release load_complete after all data
// [RL21] reconfig low holds device in reset
// [RL22] sample select once, invalid blocks load
// [RL23] init counter clears on reset, error
`timescale 1ns/1ps
`include "cfs_defs.svh"
module cfs_ctrl
   import cfs_pkg::*;
#(
   parameter logic        SECURE      = 1'h0,
   parameter logic        HAS_SEL3    = 1'h1,
   parameter int unsigned CNT_W       = 14,
   parameter int unsigned RESTART_CYC =
      `CFS_RESTART_US * 1000 / `CFS_MCLK_NS,
   parameter int unsigned INIT_CYC    =
      SECURE ? `CFS_INIT_SEC : `CFS_INIT_BASE
) (
   input  wire logic        mclk,
   input  wire logic        resetn,
   input  wire logic        ce,
   input  wire logic [3:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [31:0] rdata,
   input  wire logic        reconfig_request_n,
   input  wire logic [3:0]  scheme_select,
   input  wire logic        user_startup_clock,
   input  wire logic        test_port_active,
   input  wire logic        frame_error,
   input  wire logic        load_last,
   input  wire logic        option_valid,
   input  wire logic        option_startup_en,
   input  wire logic        config_status_n_i,
   output logic             config_status_n_o,
   output logic             config_status_n_oe,
   input  wire logic        load_complete_i,
   output logic             load_complete_o,
   output logic             load_complete_oe,
   input  wire logic        startup_complete_i,
   output logic             startup_complete_o,
   output logic             startup_complete_oe,
   output logic             load_enable,
   output logic             user_mode,
   output logic             weak_pullup_en,
   output cfs_scheme_s      scheme
);
   localparam int unsigned OSC_DIV = `CFS_OSC_NS / `CFS_MCLK_NS;
   localparam int unsigned NPIN = 8;

   // ---------------------------------------------
   // scheme decode
   // ---------------------------------------------
   function automatic cfs_scheme_s cfs_decode(
      input logic [3:0] sel
   );
      cfs_scheme_s d;
      logic [3:0]  s;
      d = '{SCH_NONE, 1'h0, 1'h0};
      // short packages see only the low three bits
      s = HAS_SEL3 ? sel : {1'h0, sel[2:0]}; // [RL19]
      case (s)
         `CFS_SEL_ASER_STD33, `CFS_SEL_ASER_STD30:
            d = '{SCH_ACTIVE_SERIAL, 1'h0, 1'h1}; // [RL13]
         `CFS_SEL_ASER_FAST33:
            d = '{SCH_ACTIVE_SERIAL, 1'h1, 1'h1}; // [RL13]
         `CFS_SEL_ASER_FAST30: begin
            // low-voltage fast variant needs the top bit
            if (HAS_SEL3) begin
               d = '{SCH_ACTIVE_SERIAL, 1'h1, 1'h1}; // [RL19]
            end
         end
         `CFS_SEL_APAR_STD33, `CFS_SEL_APAR_STD30,
         `CFS_SEL_APAR_STD18: begin
            if (!SECURE && HAS_SEL3) begin
               d = '{SCH_ACTIVE_PARALLEL, 1'h0, 1'h1}; // [RL14]
            end
         end
         // shared with the encrypted parallel codes
         `CFS_SEL_APAR_FAST33, `CFS_SEL_APAR_FAST18: begin
            if (SECURE) begin
               d = '{SCH_FAST_PASSIVE_PARALLEL_ENC,
                     1'h1, 1'h1}; // [RL17]
            end else if (HAS_SEL3) begin
               d = '{SCH_ACTIVE_PARALLEL, 1'h1, 1'h1}; // [RL14]
            end
         end
         `CFS_SEL_PSER_STD:
            d = '{SCH_PASSIVE_SERIAL, 1'h0, 1'h1}; // [RL15]
         `CFS_SEL_PSER_FAST:
            d = '{SCH_PASSIVE_SERIAL, 1'h1, 1'h1}; // [RL15]
         `CFS_SEL_FPAR_33:
            d = '{SCH_FAST_PASSIVE_PARALLEL,
                  1'h1, 1'h1}; // [RL16]
         `CFS_SEL_FPAR_18_B: begin
            if (!SECURE) begin
               d = '{SCH_FAST_PASSIVE_PARALLEL,
                     1'h1, 1'h1}; // [RL16]
            end
         end
         `CFS_SEL_FPAR_18_S: begin
            if (SECURE) begin
               d = '{SCH_FAST_PASSIVE_PARALLEL,
                     1'h1, 1'h1}; // [RL16]
            end
         end
         default: d = '{SCH_NONE, 1'h0, 1'h0}; // [RL22]
      endcase
      return d;
   endfunction

   // ---------------------------------------------
   // pin synchronisers
   // ---------------------------------------------
   logic [NPIN-1:0] pin_raw;   // asynchronous pin levels
   logic [NPIN-1:0] s1_reg;    // first stage, feeds s2 only
   logic [NPIN-1:0] s2_reg;    // second stage
   logic [NPIN-1:0] s3_reg;    // third stage
   logic [NPIN-1:0] filt_reg;  // accepted levels
   logic [NPIN-1:0] filt_next;
   logic            rcfg;      // filtered reconfig_request_n
   logic            stat_in;   // filtered status line
   logic            done_in;   // filtered load_complete line
   logic            usr_edge;  // accepted user clock rise

   assign pin_raw = {user_startup_clock, load_complete_i,
                     config_status_n_i, reconfig_request_n,
                     scheme_select};

   // a change counts once stages two and three agree
   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++) begin : g_filt
         always_comb begin
            filt_next[gi] = (s2_reg[gi] == s3_reg[gi]) ?
                            s2_reg[gi] : filt_reg[gi];
         end
      end
   endgenerate

   // shift the three stages
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         s1_reg   <= '0;
         s2_reg   <= '0;
         s3_reg   <= '0;
         filt_reg <= '0;
      end else if (ce) begin
         s1_reg   <= pin_raw;
         s2_reg   <= s1_reg;
         s3_reg   <= s2_reg;
         filt_reg <= filt_next;
      end
   end

   assign rcfg     = filt_reg[4];
   assign stat_in  = filt_reg[5];
   assign done_in  = filt_reg[6];
   assign usr_edge = filt_next[7] & ~filt_reg[7];

   // ---------------------------------------------
   // internal init oscillator
   // ---------------------------------------------
   logic [2:0] div_reg;  // divider phase
   logic [2:0] div_next;
   logic       osc_tick; // one pulse per oscillator period

   // divide mclk down to the init oscillator rate
   always_comb begin
      osc_tick = (div_reg == 3'(OSC_DIV - 1));
      div_next = osc_tick ? '0 : div_reg + 3'h1;
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         div_reg <= '0;
      end else if (ce) begin
         div_reg <= div_next;
      end
   end

   // ---------------------------------------------
   // register port
   // ---------------------------------------------
   logic        auto_reg;   // restart after error
   logic        auto_next;
   logic        usrck_reg;  // init from user clock
   logic        usrck_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   cfs_state_e  state_reg;
   cfs_state_e  state_next;
   logic        stat_oe_reg;
   logic        done_oe_reg;
   logic        start_oe_reg;
   logic        pull_reg;
   logic        user_reg;
   cfs_scheme_s scheme_reg;

   // write control, read control or status
   always_comb begin
      auto_next  = auto_reg;
      usrck_next = usrck_reg;
      rdata_next = '0;
      if (wr && addr == `CFS_REG_CTRL) begin
         auto_next  = wdata[`CFS_CTRL_AUTO];
         usrck_next = wdata[`CFS_CTRL_USRCLK];
      end
      if (rd) begin
         unique case (addr)
            `CFS_REG_CTRL: rdata_next = {30'h0, usrck_reg, auto_reg};
            `CFS_REG_STAT: rdata_next = {18'h0, user_reg, pull_reg,
                                         start_oe_reg, done_oe_reg,
                                         stat_oe_reg, scheme_reg,
                                         state_reg};
            default:       rdata_next = '0;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         auto_reg  <= `CFS_CTRL_RST_AUTO;
         usrck_reg <= `CFS_CTRL_RST_USRCLK;
         rdata_reg <= '0;
      end else if (ce) begin
         auto_reg  <= auto_next;
         usrck_reg <= usrck_next;
         rdata_reg <= rdata_next;
      end
   end

   // ---------------------------------------------
   // configuration sequencer
   // ---------------------------------------------
   logic [CNT_W-1:0] cnt_reg;  // settle, timeout, init count
   logic [CNT_W-1:0] cnt_next;
   logic             stat_oe_next;
   logic             done_oe_next;
   logic             start_oe_next;
   logic             pull_next;
   logic             user_next;
   logic             load_en_reg;
   logic             load_en_next;
   cfs_scheme_s      scheme_next;
   logic             init_tick;

   // user clock alone, or oscillator alone
   assign init_tick = usrck_reg ? usr_edge : osc_tick; // [RL4][RL6]

   always_comb begin
      state_next    = state_reg;
      cnt_next      = cnt_reg;
      stat_oe_next  = stat_oe_reg;
      done_oe_next  = done_oe_reg;
      start_oe_next = start_oe_reg;
      pull_next     = pull_reg;
      user_next     = user_reg;
      load_en_next  = 1'h0;
      scheme_next   = scheme_reg;
      unique case (state_reg)
         // let the synchronisers settle, sample once
         ST_POR: begin
            cnt_next = cnt_reg + 1'h1;
            if (cnt_reg == CNT_W'(`CFS_SETTLE)) begin
               scheme_next = cfs_decode(filt_reg[3:0]); // [RL22]
               cnt_next    = '0;
               state_next  = ST_RESET;
            end
         end
         // release status once the request is high
         ST_RESET: begin
            stat_oe_next = ~rcfg; // [RL21]
            if (rcfg && stat_in) begin
               state_next = ST_LOAD;
            end
         end
         // loading, deaf to the user clock
         ST_LOAD: begin
            load_en_next = test_port_active |
                           scheme_reg.valid; // [RL18][RL22][RL7]
            if (load_en_reg && frame_error) begin
               stat_oe_next = 1'h1; // [RL1]
               cnt_next     = '0;   // [RL23]
               state_next   = ST_ERROR;
            end else if (load_en_reg && load_last) begin
               done_oe_next = 1'h0; // [RL20]
               state_next   = ST_DONE_WAIT;
            end else if (load_en_reg && option_valid) begin
               start_oe_next = option_startup_en; // [RL10]
            end
         end
         // hold status low; time out when enabled
         ST_ERROR: begin
            if (auto_reg) begin
               cnt_next = cnt_reg + 1'h1;
               if (cnt_reg == CNT_W'(RESTART_CYC - 1)) begin
                  stat_oe_next  = 1'h0; // [RL2]
                  start_oe_next = 1'h0; // [RL10]
                  cnt_next      = '0;
                  state_next   = ST_RESET;
               end
            end
         end
         // wait for the shared done line to rise
         ST_DONE_WAIT: begin
            if (done_in) begin
               cnt_next   = '0;
               state_next = ST_INIT;
            end
         end
         // count init clocks then enter user mode
         ST_INIT: begin
            if (init_tick) begin
               cnt_next = cnt_reg + 1'h1; // [RL5]
               if (cnt_reg == CNT_W'(INIT_CYC - 1)) begin // [RL8]
                  cnt_next      = '0;
                  start_oe_next = 1'h0; // [RL11]
                  pull_next     = 1'h0; // [RL12]
                  user_next     = 1'h1;
                  state_next    = ST_USER;
               end
            end
         end
         ST_USER: begin
            user_next = 1'h1;
         end
         default: state_next = ST_RESET;
      endcase
      // request low overrides everything after power-up
      if (!rcfg && state_reg != ST_POR) begin
         state_next    = ST_RESET; // [RL21]
         stat_oe_next  = 1'h1;
         done_oe_next  = 1'h1;
         start_oe_next = 1'h0;
         pull_next     = 1'h1;
         user_next     = 1'h0;
         load_en_next  = 1'h0;
         cnt_next      = '0;       // [RL23]
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_reg    <= ST_POR;
         cnt_reg      <= '0;
         stat_oe_reg  <= 1'h1;
         done_oe_reg  <= 1'h1;
         start_oe_reg <= 1'h0;
         pull_reg     <= 1'h1;
         user_reg     <= 1'h0;
         load_en_reg  <= 1'h0;
         scheme_reg   <= '{SCH_NONE, 1'h0, 1'h0};
      end else if (ce) begin
         state_reg    <= state_next;
         cnt_reg      <= cnt_next;
         stat_oe_reg  <= stat_oe_next;
         done_oe_reg  <= done_oe_next;
         start_oe_reg <= start_oe_next;
         pull_reg     <= pull_next;
         user_reg     <= user_next;
         load_en_reg  <= load_en_next;
         scheme_reg   <= scheme_next;
      end
   end

   // ---------------------------------------------
   // outputs
   // ---------------------------------------------
   assign rdata               = rdata_reg;
   assign config_status_n_o   = `CFS_OD_LOW;
   assign config_status_n_oe  = stat_oe_reg;
   assign load_complete_o     = `CFS_OD_LOW;
   assign load_complete_oe    = done_oe_reg;
   assign startup_complete_o  = `CFS_OD_LOW;
   assign startup_complete_oe = start_oe_reg;
   assign load_enable         = load_en_reg;
   assign user_mode           = user_reg;
   assign weak_pullup_en      = pull_reg;
   assign scheme              = scheme_reg;

   // ---------------------------------------------
   // checks
   // ---------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn || !ce);

   a_err_status: assert property ( // [RL1]
      (state_reg == ST_LOAD && load_en_reg && frame_error && rcfg)
      |=> stat_oe_reg && done_oe_reg && state_reg == ST_ERROR)
      else $error("frame error did not pull status low");
   a_restart_bound: assert property ( // [RL2]
      state_reg == ST_ERROR |-> cnt_reg < CNT_W'(RESTART_CYC))
      else $error("restart timeout overran");
   a_init_hold: assert property ( // [RL4][RL6]
      (state_reg == ST_INIT && !init_tick && rcfg)
      |=> $stable(cnt_reg))
      else $error("init count moved without init clock");
   a_load_indep: assert property ( // [RL7]
      (state_reg == ST_LOAD && !frame_error && !load_last && rcfg)
      |=> state_reg == ST_LOAD)
      else $error("loading left without cause");
   a_user_entry: assert property ( // [RL8][RL11][RL12]
      (state_reg == ST_INIT && init_tick && rcfg &&
       cnt_reg == CNT_W'(INIT_CYC - 1))
      |=> user_reg && !start_oe_reg && !pull_reg)
      else $error("user mode entry wrong");
   a_start_low: assert property ( // [RL10]
      (state_reg == ST_LOAD && load_en_reg && option_valid &&
       option_startup_en && !frame_error && !load_last && rcfg)
      |=> start_oe_reg)
      else $error("startup_complete not driven low");
   a_done_release: assert property ( // [RL20]
      (state_reg == ST_LOAD && load_en_reg && load_last &&
       !frame_error && rcfg) |=> !done_oe_reg ##1 !done_oe_reg)
      else $error("load_complete not released");
   a_reset_hold: assert property ( // [RL21][RL23]
      (!rcfg && state_reg != ST_POR)
      |=> stat_oe_reg && done_oe_reg && cnt_reg == '0)
      else $error("reconfig request did not reset");
   a_test_prio: assert property ( // [RL18]
      (state_reg == ST_LOAD && test_port_active && rcfg)
      |=> load_en_reg)
      else $error("test port load blocked");
   a_scheme_once: assert property ( // [RL22]
      state_reg != ST_POR |=> $stable(scheme_reg))
      else $error("scheme resampled");
endmodule

// ---- cfs_host.sv ----
`timescale 1ns/1ps
// ---------------------------------------------
// host controller model: restart pin, user clock
// ---------------------------------------------
module cfs_host #(
   parameter int LOW_CYC = 20 // restart low time, 500 ns at 25 ns
) (
   input  wire logic mclk,
   output logic      reconfig_request_n,
   output logic      user_startup_clock
);
   // idle: no request, clock at rest low
   initial begin
      reconfig_request_n = 1'h1;
      user_startup_clock = 1'h0;
   end
   // n user clock rises, half period in mclk cycles; rests low after
   task automatic clocks(input int n, input int half);
      repeat (n) begin
         repeat (half) @(posedge mclk);
         user_startup_clock <= 1'h1;
         repeat (half) @(posedge mclk);
         user_startup_clock <= 1'h0;
      end
   endtask
   // restart pulse; clock keeps toggling while the request is low
   task automatic restart();
      @(posedge mclk);
      reconfig_request_n <= 1'h0;
      clocks(LOW_CYC / 4, 2);
      reconfig_request_n <= 1'h1;
   endtask
endmodule

// ---- cfs_ctrl_tb.sv ----
`timescale 1ns/1ps
module cfs_ctrl_tb;
   import cfs_pkg::*;
   // ---------------------------------------------
   // stimulus and observed signals
   // ---------------------------------------------
   logic        mclk, resetn, wr, rd, tp, ferr, last, optv;
   logic [3:0]  addr, sel;
   logic [31:0] wdata, rdata, v;
   logic        rq_n, usc, st_oe, st_o, lc_oe, lc_o, su_oe, su_o;
   logic        le, um, wpu, ose;
   cfs_scheme_s sch, sch_s;
   int          fails, cmp_count;
   logic [3:0]  exp_tab [16]; // {scheme, valid} per select code
   logic [3:0]  exp_s [8];    // same, short secure variant
   localparam logic [15:0] FAST = 16'hF070; // fast reset codes
   localparam logic [7:0]  FAST_S = 8'h62;  // fast codes, short secure
   localparam logic [3:0]  Q_ENC = {SCH_FAST_PASSIVE_PARALLEL_ENC, 1'h1};
   localparam logic [3:0]  Q_NONE = {SCH_NONE, 1'h0};
   localparam logic [3:0]  Q_ASER = {SCH_ACTIVE_SERIAL, 1'h1};
   localparam logic [3:0]  Q_APAR = {SCH_ACTIVE_PARALLEL, 1'h1};
   localparam logic [3:0]  Q_PSER = {SCH_PASSIVE_SERIAL, 1'h1};
   localparam logic [3:0]  Q_FPAR = {SCH_FAST_PASSIVE_PARALLEL, 1'h1};
   // open-drain wires with pull-ups
   wire st_w = st_oe ? st_o : 1'h1;
   wire lc_w = lc_oe ? lc_o : 1'h1;
   wire su_w = su_oe ? su_o : 1'h1;

   cfs_ctrl #(.RESTART_CYC(20), .INIT_CYC(10)) dut (
      .mclk(mclk), .resetn(resetn), .ce(1'h1), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .reconfig_request_n(rq_n), .scheme_select(sel),
      .user_startup_clock(usc), .test_port_active(tp),
      .frame_error(ferr), .load_last(last), .option_valid(optv),
      .option_startup_en(ose), .config_status_n_i(st_w),
      .config_status_n_o(st_o), .config_status_n_oe(st_oe),
      .load_complete_i(lc_w), .load_complete_o(lc_o),
      .load_complete_oe(lc_oe), .startup_complete_i(su_w),
      .startup_complete_o(su_o), .startup_complete_oe(su_oe),
      .load_enable(le), .user_mode(um), .weak_pullup_en(wpu),
      .scheme(sch));
   cfs_host host (.mclk(mclk), .reconfig_request_n(rq_n),
      .user_startup_clock(usc));
   // security variant on a short package, decode checked only
   cfs_ctrl #(.SECURE(1'h1), .HAS_SEL3(1'h0), .RESTART_CYC(20),
      .INIT_CYC(10)) dut_s (
      .mclk(mclk), .resetn(resetn), .ce(1'h1), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(),
      .reconfig_request_n(rq_n), .scheme_select(sel),
      .user_startup_clock(usc), .test_port_active(tp),
      .frame_error(ferr), .load_last(last), .option_valid(optv),
      .option_startup_en(ose), .config_status_n_i(st_w),
      .config_status_n_o(), .config_status_n_oe(),
      .load_complete_i(lc_w), .load_complete_o(),
      .load_complete_oe(), .startup_complete_i(su_w),
      .startup_complete_o(), .startup_complete_oe(),
      .load_enable(), .user_mode(), .weak_pullup_en(),
      .scheme(sch_s));

   // 40 MHz clock
   initial begin
      mclk = 1'h0;
      forever #12.5 mclk = ~mclk;
   end
   // ---------------------------------------------
   // shared tasks
   // ---------------------------------------------
   task automatic close_out();
      $display("compares=%0d mismatches=%0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   function automatic logic sig(input int k);
      case (k)
         0: sig = le;
         1: sig = um;
         default: sig = st_oe;
      endcase
   endfunction
   // bounded wait for a level; running out ends the run
   task automatic wait_for(input int k, input logic val, input int max);
      for (int i = 0; i < max; i++) begin
         tick(1);
         if (sig(k) === val) return;
      end
      fails++;
      close_out();
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'h1;
      @(posedge mclk);
      wr <= 1'h0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      rd <= 1'h1;
      @(posedge mclk);
      rd <= 1'h0;
      #1;
      d = rdata;
   endtask
   // loader pulse: 0 frame error, 1 last data, 2 option frame
   task automatic pulse(input int k);
      @(posedge mclk);
      ferr <= (k == 0);
      last <= (k == 1);
      optv <= (k == 2);
      @(posedge mclk);
      {ferr, last, optv} <= 3'h0;
      #1;
   endtask
   task automatic do_reset(input logic [3:0] s);
      @(posedge mclk);
      resetn <= 1'h0;
      sel <= s;
      repeat (12) @(posedge mclk);
      resetn <= 1'h1;
   endtask
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      {resetn, wr, rd, tp, ferr, last, optv} = 7'h0;
      addr = 4'h0;
      wdata = 32'h0;
      sel = 4'h2;
      fails = 0;
      cmp_count = 0;
      ose = 1'h1;
      exp_tab = '{Q_PSER, Q_NONE, Q_ASER, Q_ASER, Q_ASER, Q_APAR,
         Q_APAR, Q_APAR, Q_APAR, Q_NONE, Q_NONE, Q_APAR, Q_PSER,
         Q_ASER, Q_FPAR, Q_FPAR};
      exp_s = '{Q_PSER, Q_FPAR, Q_ASER, Q_ASER, Q_NONE, Q_ENC, Q_ENC,
         Q_NONE};
      // every select code, one reset each
      for (int c = 0; c < 16; c++) begin
         do_reset(c[3:0]);
         tick(12);
         check({sch.scheme, sch.valid}, exp_tab[c]);
         if (exp_tab[c][0]) check(sch.fast_por, FAST[c]);
         check({sch_s.scheme, sch_s.valid}, exp_s[c[2:0]]);
         if (exp_s[c[2:0]][0]) begin
            check(sch_s.fast_por, FAST_S[c[2:0]]);
         end
      end
      // invalid code blocks loading unless the test port runs
      do_reset(4'h9);
      tick(40);
      check(le, 1'h0);
      @(posedge mclk);
      tp <= 1'h1;
      wait_for(0, 1'h1, 40);
      @(posedge mclk);
      tp <= 1'h0;
      // registers after reset, unmapped read
      do_reset(4'h2);
      rd_reg(4'h0, v);
      check(v, 32'h1);
      rd_reg(4'h8, v);
      check(v, 32'h0);
      rd_reg(4'h4, v);
      check(v[13:12], 2'h1);
      wait_for(0, 1'h1, 40);
      check(su_oe, 1'h0);
      // option frame with the startup pin disabled
      ose <= 1'h0;
      pulse(2);
      check(su_oe, 1'h0);
      ose <= 1'h1;
      pulse(2);
      tick(2);
      check(su_oe, 1'h1);
      // frame error with automatic restart
      pulse(0);
      check(st_oe, 1'h1);
      check(lc_oe, 1'h1);
      check({st_o, lc_o, su_o}, 3'h0);
      tick(15);
      check(st_oe, 1'h1);
      wait_for(2, 1'h0, 20);
      check(su_oe, 1'h0);
      wait_for(0, 1'h1, 40);
      // automatic restart off: host restarts
      wr_reg(4'h0, 32'h0);
      pulse(0);
      tick(60);
      check(st_oe, 1'h1);
      host.restart();
      tick(1);
      check(lc_oe, 1'h1);
      check(su_oe, 1'h0);
      wait_for(0, 1'h1, 40);
      // success on the internal oscillator
      pulse(2);
      pulse(1);
      check(lc_oe, 1'h0);
      tick(30);
      check(um, 1'h0);
      wait_for(1, 1'h1, 60);
      check(su_oe, 1'h0);
      check(su_w, 1'h1);
      check(wpu, 1'h0);
      rd_reg(4'h4, v);
      check(v[13:12], 2'h2);
      check(v[3:0], ST_USER);
      // user startup clock, aborted init, then exact count
      wr_reg(4'h0, 32'h3);
      host.restart();
      wait_for(0, 1'h1, 40);
      pulse(2);
      host.clocks(5, 2);
      pulse(1);
      host.clocks(5, 2);
      host.restart();
      wait_for(0, 1'h1, 40);
      pulse(2);
      pulse(1);
      tick(20);
      check(um, 1'h0);
      host.clocks(9, 2);
      tick(10);
      check(um, 1'h0);
      host.clocks(1, 2);
      wait_for(1, 1'h1, 20);
      check(wpu, 1'h0);
      close_out();
   end
endmodule
